// ==== rtl/standalone_defs.vh ====
// Constants for the standalone programming sequencer
// Assumes a 10 MHz mclk; all times converted to cycles here
`ifndef STANDALONE_DEFS_VH
`define STANDALONE_DEFS_VH
`define CLK_HZ          10000000
`define BLINK_ON_MS     100
`define BLINK_OFF_MS    200
`define GROUP_GAP_MS    800
`define RAPID_MS        50
`define BLINK_ON_CYC    ((`CLK_HZ / 1000) * `BLINK_ON_MS)
`define BLINK_OFF_CYC   ((`CLK_HZ / 1000) * `BLINK_OFF_MS)
`define GROUP_GAP_CYC   ((`CLK_HZ / 1000) * `GROUP_GAP_MS)
`define RAPID_CYC       ((`CLK_HZ / 1000) * `RAPID_MS)
`define ERR_NONE        3'h0
`define ERR_SUPPLY      3'h1
`define ERR_IDENT       3'h2
`define ERR_VERIFY      3'h3
`define ERR_INTERNAL    3'h4
`define LED_OFF         2'h0
`define LED_GREEN       2'h1
`define LED_RED         2'h2
`define LED_ORANGE      2'h3
`endif

// ==== rtl/button_edge.v ====
// Button press detector: one-cycle pulse on the rising edge of a level
// Assumes the button input is already debounced and synchronous to mclk
module button_edge
(
    // Clock and reset
    input  wire mclk,
    input  wire sys_rst,
    // Button
    input  wire level,
    output wire press
);
    reg level_q;

    always @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
            level_q <= 1'b0;
        else
            level_q <= level;
    end

    assign press = level & ~level_q;
endmodule

// ==== rtl/blink_gen.v ====
// Blink pattern generator: groups of n blinks, repeated after a gap, or a single group of n blinks
// Assumes start is a one-cycle pulse; counts come from the parent
module blink_gen
#(
    parameter ON_CYC  = 1000000,
    parameter OFF_CYC = 2000000,
    parameter GAP_CYC = 8000000
)
(
    // Clock and reset
    input  wire       mclk,
    input  wire       sys_rst,
    // Control
    input  wire       start,
    input  wire       stop,
    input  wire [2:0] count,
    input  wire       repeat_en,
    // Output
    output reg        lit,
    output wire       busy
);
    reg [23:0] tmr_q;
    reg [2:0]  done_q;
    reg        run_q;

    assign busy = run_q;

    always @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            tmr_q  <= 24'h0;
            done_q <= 3'h0;
            run_q  <= 1'b0;
            lit    <= 1'b0;
        end
        else if (start)
        begin
            // Start wins: it arrives while the parent is still leaving the old state
            run_q  <= 1'b1;
            lit    <= 1'b1;
            done_q <= 3'h0;
            tmr_q  <= ON_CYC[23:0] - 24'h1;
        end
        else if (stop)
        begin
            run_q <= 1'b0;
            lit   <= 1'b0;
        end
        else if (run_q)
        begin
            if (tmr_q != 24'h0)
                tmr_q <= tmr_q - 24'h1;
            else if (lit)
            begin
                lit    <= 1'b0;
                done_q <= done_q + 3'h1;
                if (done_q + 3'h1 >= count)
                begin
                    if (repeat_en)
                        tmr_q <= GAP_CYC[23:0] - 24'h1;
                    else
                        run_q <= 1'b0;
                end
                else
                    tmr_q <= OFF_CYC[23:0] - 24'h1;
            end
            else
            begin
                if (done_q >= count)
                    done_q <= 3'h0;
                lit   <= 1'b1;
                tmr_q <= ON_CYC[23:0] - 24'h1;
            end
        end
    end
endmodule

// ==== rtl/standalone_programmer_sequencer.v ====
// Standalone programming sequencer: button-started programming with LED feedback
// Assumes the programming engine, image store and host link are outside;
// inputs are synchronous to mclk and the button is debounced
`include "standalone_defs.vh"
module standalone_programmer_sequencer
#(
    parameter BLINK_ON_CYC  = `BLINK_ON_CYC,
    parameter BLINK_OFF_CYC = `BLINK_OFF_CYC,
    parameter GROUP_GAP_CYC = `GROUP_GAP_CYC,
    parameter RAPID_CYC     = `RAPID_CYC
)
(
    // Clock and reset
    input  wire       mclk,
    input  wire       sys_rst,
    // Image store and host
    input  wire       image_stored,
    input  wire       host_connected,
    input  wire       host_keep,
    input  wire       host_erase,
    output reg        image_erase,
    // User
    input  wire       push_button,
    // Target setup
    input  wire       baseline_part,
    input  wire       family_16bit,
    // Programming engine
    output reg        prog_start,
    output reg        use_executive,
    output reg        debug_enable,
    input  wire       prog_done,
    input  wire       supply_fail,
    input  wire       id_checked,
    input  wire       id_match,
    input  wire       verify_fail,
    input  wire       internal_fault,
    // Indicators
    output reg        standalone_programming_mode,
    output reg        activity_led,
    output reg  [1:0] status_led,
    output reg  [2:0] error_code
);

    localparam [4:0] S_IDLE  = 5'h01;
    localparam [4:0] S_READY = 5'h02;
    localparam [4:0] S_PROG  = 5'h04;
    localparam [4:0] S_ERROR = 5'h08;
    localparam [4:0] S_HOST  = 5'h10;

    reg  [4:0]  state_q;
    reg  [4:0]  state_d;
    reg  [2:0]  err_d;
    reg  [23:0] rapid_q;
    reg         rapid_lit_q;
    wire        press;
    wire        act_lit;
    wire        err_lit;
    reg         act_start;
    reg         err_start;
    reg  [2:0]  err_count;
    reg         prog_seen_q;

    button_edge u_button
    (
        .mclk    (mclk),
        .sys_rst (sys_rst),
        .level   (push_button),
        .press   (press)
    );

    // Single activity blink on ready entry and on success
    blink_gen #(
        .ON_CYC  (BLINK_ON_CYC),
        .OFF_CYC (BLINK_OFF_CYC),
        .GAP_CYC (GROUP_GAP_CYC)
    ) u_act
    (
        .mclk      (mclk),
        .sys_rst   (sys_rst),
        .start     (act_start),
        .stop      (state_q != S_READY),
        .count     (3'h1),
        .repeat_en (1'b0),
        .lit       (act_lit),
        .busy      ()
    );

    // Grouped red blinks for error codes
    blink_gen #(
        .ON_CYC  (BLINK_ON_CYC),
        .OFF_CYC (BLINK_OFF_CYC),
        .GAP_CYC (GROUP_GAP_CYC)
    ) u_err
    (
        .mclk      (mclk),
        .sys_rst   (sys_rst),
        .start     (err_start),
        .stop      (state_q != S_ERROR),
        .count     (err_count),
        .repeat_en (1'b1),
        .lit       (err_lit),
        .busy      ()
    );

    always @*
    begin
        if (error_code == `ERR_IDENT)
            err_count = 3'h2;
        else if (error_code == `ERR_VERIFY)
            err_count = 3'h3;
        else
            err_count = 3'h4;
    end

    // Result classification, internal fault first, then supply
    always @*
    begin
        err_d = `ERR_NONE;
        if (internal_fault)
            err_d = `ERR_INTERNAL;
        else if (supply_fail)
            err_d = `ERR_SUPPLY;
        else if (id_checked && !id_match && !baseline_part)
            err_d = `ERR_IDENT;
        else if (prog_done && verify_fail)
            err_d = `ERR_VERIFY;
    end

    always @*
    begin
        state_d = state_q;
        case (state_q)
            S_IDLE:
                if (host_connected)
                    state_d = S_HOST;
                else if (image_stored)
                    state_d = S_READY;
            S_READY:
                if (host_connected)
                    state_d = S_HOST;
                else if (press)
                    state_d = S_PROG;
            S_PROG:
                if (err_d != `ERR_NONE)
                    state_d = S_ERROR;
                else if (prog_done)
                    state_d = S_READY;
            S_ERROR:
                if (host_connected)
                    state_d = S_HOST;
                else if (press)
                    state_d = S_PROG;
            S_HOST:
                if (host_erase)
                    state_d = S_IDLE;
                else if (host_keep && !host_connected)
                    state_d = S_READY;
            default:
                state_d = S_IDLE;
        endcase
    end

    always @*
    begin
        act_start = (state_d == S_READY) && (state_q != S_READY);
        err_start = (state_d == S_ERROR) && (state_q != S_ERROR);
    end

    always @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            state_q     <= S_IDLE;
            error_code  <= `ERR_NONE;
            prog_start  <= 1'b0;
            image_erase <= 1'b0;
            rapid_q     <= 24'h0;
            rapid_lit_q <= 1'b0;
        end
        else
        begin
            state_q     <= state_d;
            prog_start  <= (state_q != S_PROG) && (state_d == S_PROG);
            image_erase <= (state_q == S_HOST) && host_erase;
            if (state_d == S_ERROR && state_q == S_PROG)
                error_code <= err_d;
            else if (state_d == S_PROG)
                error_code <= `ERR_NONE;
            if (rapid_q == 24'h0)
            begin
                rapid_q     <= RAPID_CYC[23:0] - 24'h1;
                rapid_lit_q <= ~rapid_lit_q;
            end
            else
                rapid_q <= rapid_q - 24'h1;
        end
    end

    // Presses in S_PROG have no transition, so they are dropped

    always @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            standalone_programming_mode <= 1'b0;
            debug_enable                <= 1'b0;
            use_executive               <= 1'b0;
            activity_led                <= 1'b0;
            status_led                  <= `LED_OFF;
        end
        else
        begin
            standalone_programming_mode <= (state_q != S_IDLE) && (state_q != S_HOST);
            debug_enable                <= (state_q == S_HOST);
            use_executive               <= (state_q == S_HOST) && family_16bit;
            activity_led                <= (state_q == S_READY) && act_lit;
            if (state_q == S_PROG)
                status_led <= `LED_ORANGE;
            else if (state_q == S_ERROR)
            begin
                if (error_code == `ERR_SUPPLY)
                    status_led <= rapid_lit_q ? `LED_RED : `LED_OFF;
                else
                    status_led <= err_lit ? `LED_RED : `LED_OFF;
            end
            else if (state_q == S_READY && error_code == `ERR_NONE && prog_seen_q)
                status_led <= `LED_GREEN;
            else
                status_led <= `LED_OFF;
        end
    end

    always @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
            prog_seen_q <= 1'b0;
        else if (state_q == S_PROG && state_d == S_READY)
            prog_seen_q <= 1'b1;
        else if (state_q != S_READY && state_q != S_PROG)
            prog_seen_q <= 1'b0;
    end
endmodule

// ==== verif/sps_target_model.sv ====
// Target model: answers a programming run after lat cycles with the result kind
// Assumes kind and lat are set by the bench before the button press
module sps_target_model
(
    // Clock and reset
    input  wire logic       mclk,
    input  wire logic       sys_rst,
    // Control
    input  wire logic       prog_start,
    input  wire logic [2:0] kind,
    input  wire logic [3:0] lat,
    // Results
    output wire logic       prog_done,
    output wire logic       supply_fail,
    output wire logic       id_checked,
    output wire logic       id_match,
    output wire logic       verify_fail,
    output wire logic       internal_fault
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [4:0] cnt_q;
    wire        fin = (cnt_q == 5'h1);
    always @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
            cnt_q <= 5'h0;
        else if (prog_start)
            cnt_q <= {1'b0, lat} + 5'h1;
        else if (cnt_q != 5'h0)
            cnt_q <= cnt_q - 5'h1;
    end
    assign supply_fail    = fin && kind == 3'h1;
    assign internal_fault = fin && kind == 3'h4;
    assign prog_done      = fin && kind != 3'h1 && kind != 3'h4;
    assign id_checked     = prog_done;
    assign id_match       = !(kind == 3'h2 || kind == 3'h5);
    assign verify_fail    = prog_done && kind == 3'h3;
endmodule

// ==== verif/standalone_programmer_sequencer_assertions.sv ====
// Checker for the standalone programming sequencer
// Assumes it is bound to the top module and sees only its ports
module sps_checker
(
    // Clock and reset
    input wire logic       mclk,
    input wire logic       sys_rst,
    // Inputs
    input wire logic       host_erase,
    input wire logic       push_button,
    input wire logic       baseline_part,
    input wire logic       prog_done,
    input wire logic       supply_fail,
    input wire logic       id_checked,
    input wire logic       id_match,
    input wire logic       verify_fail,
    input wire logic       internal_fault,
    // Outputs
    input wire logic       image_erase,
    input wire logic       prog_start,
    input wire logic       use_executive,
    input wire logic       debug_enable,
    input wire logic       standalone_programming_mode,
    input wire logic       activity_led,
    input wire logic [1:0] status_led,
    input wire logic [2:0] error_code
);
    default clocking @(posedge mclk); endclocking
    default disable iff (sys_rst);
    wire quiet = !supply_fail && !internal_fault;
    sequence press_ready_s;
        $rose(push_button) && standalone_programming_mode && status_led != 2'h3;
    endsequence
    property code_p(logic cause, logic [2:0] code);
        cause && status_led == 2'h3 |-> ##[1:2] error_code == code;
    endproperty
    debug_off_a: assert property (standalone_programming_mode |-> !debug_enable) else $error("debug on");
    no_exec_a: assert property (standalone_programming_mode |-> !use_executive) else $error("executive");
    press_start_a: assert property (press_ready_s |-> ##[1:3] prog_start) else $error("no start");
    busy_ignore_a: assert property (status_led == 2'h3 && $past(status_led) == 2'h3 |-> !prog_start)
        else $error("start while busy");
    error_dark_a: assert property ((error_code != 3'h0)[*2] |-> !activity_led) else $error("activity lit");
    ok_green_a: assert property (prog_done && quiet && !verify_fail && id_match && status_led == 2'h3
        |-> ##[1:3] status_led == 2'h1) else $error("no green");
    supply_code_a: assert property (code_p(supply_fail && !internal_fault, 3'h1)) else $error("supply");
    internal_code_a: assert property (code_p(internal_fault, 3'h4)) else $error("internal");
    ident_code_a: assert property (code_p(prog_done && quiet && !id_match && !baseline_part, 3'h2))
        else $error("ident");
    verify_code_a: assert property (code_p(prog_done && quiet && verify_fail && id_match, 3'h3))
        else $error("verify");
    erase_pulse_a: assert property (image_erase |-> $past(host_erase)) else $error("erase");
endmodule
bind standalone_programmer_sequencer sps_checker sps_checker_i (.mclk, .sys_rst, .host_erase, .push_button,
    .baseline_part, .prog_done, .supply_fail, .id_checked, .id_match, .verify_fail, .internal_fault, .image_erase,
    .prog_start, .use_executive, .debug_enable, .standalone_programming_mode, .activity_led, .status_led, .error_code);

// ==== verif/standalone_programmer_sequencer_test.sv ====
// Testbench for the standalone programming sequencer
// Assumes short blink counts 4, 4, 16, 2 cycles and the target model
`include "standalone_defs.vh"
module standalone_programmer_sequencer_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic       mclk = 0, sys_rst = 1, image_stored = 1, host_connected = 0, host_keep = 0, host_erase = 0;
    logic       push_button = 0, baseline_part = 0, family_16bit = 0, act_q = 0, red_q = 0;
    logic [2:0] kind = 0;
    logic [3:0] lat = 4;
    logic [2:0] cases [8] = '{0, 3, 0, 2, 4, 1, 5, 0};
    logic [31:0] seed = 32'h2db0;
    wire        prog_done, supply_fail, id_checked, id_match, verify_fail, internal_fault;
    wire        image_erase, prog_start, use_executive, debug_enable, standalone_programming_mode, activity_led;
    wire [1:0]  status_led;
    wire [2:0]  error_code;
    int         fail_count = 0, compares = 0, starts = 0, acts = 0, reds = 0, dark = 0, erases = 0, s0, a0, r0;
    standalone_programmer_sequencer #(.BLINK_ON_CYC(4), .BLINK_OFF_CYC(4), .GROUP_GAP_CYC(16), .RAPID_CYC(2))
        standalone_programmer_sequencer_i (.mclk, .sys_rst, .image_stored, .host_connected, .host_keep,
        .host_erase, .image_erase, .push_button, .baseline_part, .family_16bit, .prog_start, .use_executive,
        .debug_enable, .prog_done, .supply_fail, .id_checked, .id_match, .verify_fail, .internal_fault,
        .standalone_programming_mode, .activity_led, .status_led, .error_code);
    sps_target_model sps_target_model_i (.mclk, .sys_rst, .prog_start, .kind, .lat, .prog_done, .supply_fail,
        .id_checked, .id_match, .verify_fail, .internal_fault);
    initial
    begin
        forever #50 mclk = ~mclk;
    end
    always @(posedge mclk)
    begin
        act_q <= activity_led;
        red_q <= (status_led == `LED_RED);
        dark <= (status_led == `LED_RED) ? 0 : dark + 1;
        if (prog_start === 1'b1) starts <= starts + 1;
        if (activity_led === 1'b1 && act_q === 1'b0) acts <= acts + 1;
        if (status_led === `LED_RED && !red_q) reds <= reds + 1;
        if (image_erase === 1'b1) erases <= erases + 1;
    end
    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    function automatic logic [2:0] exp_code(input logic [2:0] k);
        return (k == 3'h5) ? `ERR_NONE : k;
    endfunction
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp)
        begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic finish_test();
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic press();
        @(posedge mclk) push_button <= 1'b1;
        @(posedge mclk) push_button <= 1'b0;
    endtask
    task automatic run_op(input logic [2:0] k);
        seed = xs(seed);
        s0 = starts;
        a0 = acts;
        @(posedge mclk);
        kind <= k;
        baseline_part <= (k == 3'h5);
        family_16bit <= seed[3];
        lat <= 4'h4 + {1'b0, seed[2:0]};
        press();
        repeat (3) @(negedge mclk);
        chk("orange", 8'(`LED_ORANGE), 8'(status_led));
        press();
        repeat (60) @(negedge mclk);
        chk("starts", 8'h1, 8'(starts - s0));
        chk("code", 8'(exp_code(k)), 8'(error_code));
        if (exp_code(k) == `ERR_NONE)
        begin
            chk("green", 8'(`LED_GREEN), 8'(status_led));
            chk("blue", 8'h1, 8'(acts - a0));
        end
        else
        begin
            chk("activity", 8'h0, 8'(activity_led));
            r0 = reds;
            if (k == 3'h1)
            begin
                repeat (80) @(negedge mclk);
                chk("rapid", 8'h1, 8'(reds - r0 >= 10));
            end
            else
            begin
                while (dark < 10) @(negedge mclk);
                r0 = reds;
                while (reds == r0 || dark < 10) @(negedge mclk);
                chk("blinks", 8'(k), 8'(reds - r0));
            end
        end
        $display("op kind %0d done", k);
    endtask
    initial
    begin
        repeat (2) @(posedge mclk);
        sys_rst <= 1'b0;
        repeat (60) @(negedge mclk);
        chk("mode", 8'h1, 8'(standalone_programming_mode));
        chk("ready blink", 8'h1, 8'(acts));
        foreach (cases[i]) run_op(cases[i]);
        repeat (6)
        begin
            seed = xs(seed);
            run_op(3'(seed % 6));
        end
        @(posedge mclk) host_connected <= 1'b1;
        repeat (4) @(posedge mclk);
        host_erase <= 1'b1;
        @(posedge mclk) host_erase <= 1'b0;
        repeat (6) @(negedge mclk);
        chk("erase", 8'h1, 8'(erases));
        chk("mode off", 8'h0, 8'(standalone_programming_mode));
        finish_test();
    end
    initial
    begin
        repeat (8000) @(posedge mclk);
        fail_count++;
        finish_test();
    end
endmodule
